// ===== hw/swr_pkg.sv
// package for the warm reset sequencer: register map, fields, timing
package swr_pkg;
   // register byte addresses (32-bit aligned)
   localparam logic [11:0] SWR_CTRL_ADDR   = 12'h000;
   localparam logic [11:0] SWR_STATUS_ADDR = 12'h004;
   localparam logic [11:0] SWR_CFG_ADDR    = 12'h008;
   // control register fields
   localparam int SWR_CTRL_BIDIR_BIT = 3;
   localparam int SWR_CTRL_SWRST_BIT = 0;
   // status register fields
   localparam int SWR_STAT_SHORT_BIT = 0;
   localparam int SWR_STAT_LONG_BIT  = 1;
   localparam int SWR_STAT_SW_BIT    = 2;
   localparam int SWR_STAT_ASYNC_BIT = 3;
   localparam int SWR_STAT_BUSY_BIT  = 4;
   // config port fields
   localparam int SWR_CLK_HI  = 15;
   localparam int SWR_CLK_LO  = 13;
   localparam int SWR_SW_HI   = 12;
   localparam int SWR_SW_LO   = 8;
   localparam int SWR_CLR_HI  = 7;
   localparam int SWR_CLR_LO  = 2;
   // reset values
   localparam logic [15:0] SWR_CFG_RESET  = 16'hffff;
   localparam logic [23:0] SWR_BOOT_ADDR  = 24'h00_0000;
   localparam logic [15:0] SWR_FLASH_IDLE = 16'hffff;
   // timing in half-clock units; two half-clock units per cpu clock
   localparam int SWR_HCU_PER_CLK = 2;
   localparam int SWR_MIN_PULSE_HCU = 4;
   localparam int SWR_SETTLE_HCU    = 12;
   localparam int SWR_START_HCU     = 16;
   localparam int SWR_SEQ_HCU       = 1024;
   localparam int SWR_SAMPLE_HCU    = 8;
   localparam int SWR_TRANS_END_HCU = 4;
   localparam int SWR_EXIT_HCU      = 8;
   localparam int SWR_MIN_PULSE_CYC = (SWR_MIN_PULSE_HCU + SWR_HCU_PER_CLK - 1) / SWR_HCU_PER_CLK;
   localparam int SWR_SETTLE_CYC    = SWR_SETTLE_HCU / SWR_HCU_PER_CLK;
   localparam int SWR_SEQ_CYC       = SWR_SEQ_HCU / SWR_HCU_PER_CLK;
   localparam int SWR_SAMPLE_CYC    = SWR_SAMPLE_HCU / SWR_HCU_PER_CLK;
   localparam int SWR_TRANS_END_CYC = SWR_TRANS_END_HCU / SWR_HCU_PER_CLK;
   localparam int SWR_EXIT_CYC      = SWR_EXIT_HCU / SWR_HCU_PER_CLK;
   typedef enum logic [2:0] {
      SWR_IDLE, SWR_DETECT, SWR_SETTLE, SWR_SEQ, SWR_SAMPLE, SWR_HOLD, SWR_EXIT, SWR_ASYNC
   } swr_state_t;
endpackage

// ===== hw/swr_sequencer.sv
// warm and software reset sequencer with apb register access
`timescale 1ns/10ps
`default_nettype none
// Operation
// R1: warm reset starts when reset input falls while capacitor pin reads high.
// R2: outside source holds reset input low at least four half-clock units.
// R3: on reset entry tristate general pins and drive reset output low.
// R4: within twelve units cancel holds, finish internal access, abort external cycle.
// R5: reset-pin pull-down only when bidirectional enable set; enable cleared by resets.
// R6: after at most sixteen units run internal sequence of exactly 1024 units.
// R7: eight units after sequence sample filtered input; high short, low also long.
// R8: long reset makes config bits 15..13 transparent; ends 3-4 units after release.
// R9: bidirectional mode holds reset pin low through sequence, releases at its end.
// R10: extend reset until input high; internal boot waits for flash init done.
// R11: on exit latch configuration, strobes inactive, fetch from address zero.
// R12: capacitor pin pull-down enabled whenever reset input is low.
// R13: capacitor pin low during hardware warm reset escalates to completed async reset.
// R14: software reset completes regardless of capacitor pin level.
// R15: capacitor sensing is gated by filtered reset input, not raw pin.
// R16: software reset instruction starts internal sequence any time, like short reset; the code accepts it only in SWR_IDLE.
// R17: software reset end latches config bits 12..8, sets bits 7..2 to one.
// R18: bidirectional software reset drives reset pin only while capacitor pin high.
// R19: pulse shorter than four units resets only the flash, which then reads ffff.
// R20: external boot releases internal reset a few units after input goes high.
// R21: filtered reset input is synchronised before counting or sampling.
module swr_sequencer
   import swr_pkg::*;
#(
   parameter int SEQ_CYC = SWR_SEQ_CYC
) (
   // clock, reset, enable
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        clk_en,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // pins and sensing
   input  wire logic        filtered_reset_in,
   input  wire logic        powerdown_cap_pin,
   input  wire logic        boot_memory_select,
   input  wire logic [15:0] config_port,
   input  wire logic        flash_init_done,
   input  wire logic        software_reset_instr,
   output logic             reset_input_n_o,
   output logic             reset_input_n_oe_n,
   output logic             powerdown_pulldown_en,
   output logic             reset_output_n,
   output logic             io_tristate,
   output logic             bus_abort,
   output logic             hold_cancel,
   output logic             strobes_inactive,
   output logic             internal_reset,
   output logic             async_reset_req,
   output logic             flash_reset,
   output logic [23:0]      fetch_addr,
   output logic             fetch_start,
   output logic [15:0]      system_config
);
   import swr_pkg::*;

   swr_state_t  state_reg;
   logic [1:0]  rst_sync_reg;
   logic [1:0]  cap_sync_reg;
   logic [9:0]  cnt_reg;
   logic [3:0]  low_cnt_reg;
   logic        bidir_reg;
   logic        sw_reg;
   logic        short_reg;
   logic        long_reg;
   logic        async_flag_reg;
   logic        trans_reg;
   logic [1:0]  trans_cnt_reg;
   logic [15:0] cfg_reg;
   logic        swreq_reg;
   logic        flash_rst_reg;

   wire logic rst_low  = ~rst_sync_reg[1];   // see R21
   wire logic cap_high = cap_sync_reg[1];
   wire logic busy     = (state_reg != SWR_IDLE);

   function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] r);
      return a == r;
   endfunction

   wire logic wr_en = psel & penable & pwrite;
   wire logic sw_trig = software_reset_instr | swreq_reg;   // see R16

   // last cycle of the sample window after the internal sequence
   function automatic logic sample_done(input swr_state_t s, input logic [9:0] c);
      return (s == SWR_SAMPLE) && (c == 10'(SWR_SAMPLE_CYC - 1));
   endfunction

   // last reset cycle: internal boot already waited for the flash, so it leaves at once
   function automatic logic exit_done(input swr_state_t s, input logic [9:0] c,
                                      input logic int_boot);
      return (s == SWR_EXIT) && (int_boot || c == 10'(SWR_EXIT_CYC - 1));
   endfunction

   wire logic sample_end = sample_done(state_reg, cnt_reg);
   wire logic exit_end   = exit_done(state_reg, cnt_reg, boot_memory_select);

   // two-stage synchronisers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_sync_reg <= 2'h3;
         cap_sync_reg <= 2'h3;
      end else if (clk_en) begin
         rst_sync_reg <= {rst_sync_reg[0], filtered_reset_in};   // see R21
         cap_sync_reg <= {cap_sync_reg[0], powerdown_cap_pin};
      end
   end

   // reset input low-time counter for pulse qualification
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         low_cnt_reg   <= 4'h0;
         flash_rst_reg <= 1'b0;
      end else if (clk_en) begin
         flash_rst_reg <= 1'b0;
         if (rst_low) begin
            if (low_cnt_reg != 4'hf)
               low_cnt_reg <= low_cnt_reg + 4'h1;
         end else begin
            // too short for a system reset: only the flash sees it
            // a pulse that only reached detection never started the sequence
            if (low_cnt_reg != 4'h0 && low_cnt_reg < 4'(SWR_MIN_PULSE_CYC)
                && (state_reg == SWR_IDLE || state_reg == SWR_DETECT))
               flash_rst_reg <= 1'b1;   // see R19
            low_cnt_reg <= 4'h0;
         end
      end
   end

   // main sequence
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg      <= SWR_IDLE;
         cnt_reg        <= 10'h000;
         sw_reg         <= 1'b0;
         async_flag_reg <= 1'b0;
      end else if (clk_en) begin
         case (state_reg)
            SWR_IDLE: begin
               cnt_reg <= 10'h000;
               if (sw_trig) begin
                  sw_reg         <= 1'b1;
                  async_flag_reg <= 1'b0;
                  state_reg      <= SWR_SETTLE;   // see R16
               end else if (rst_low && cap_high) begin
                  sw_reg         <= 1'b0;
                  async_flag_reg <= 1'b0;
                  state_reg      <= SWR_DETECT;   // see R1
               end
            end
            SWR_DETECT: begin
               if (!rst_low)
                  state_reg <= SWR_IDLE;
               else if (low_cnt_reg >= 4'(SWR_MIN_PULSE_CYC)) begin
                  cnt_reg   <= 10'h000;
                  state_reg <= SWR_SETTLE;   // see R2
               end
            end
            SWR_SETTLE: begin
               // 12 half-clock units of hold cancel, 16 total from detection
               if (cnt_reg == 10'(SWR_SETTLE_CYC - 1)) begin
                  cnt_reg   <= 10'h000;
                  state_reg <= SWR_SEQ;   // see R4 R6
               end else
                  cnt_reg <= cnt_reg + 10'h001;
            end
            SWR_SEQ: begin
               if (cnt_reg == 10'(SEQ_CYC - 1)) begin
                  cnt_reg   <= 10'h000;
                  state_reg <= SWR_SAMPLE;   // see R6
               end else
                  cnt_reg <= cnt_reg + 10'h001;
            end
            SWR_SAMPLE: begin
               if (cnt_reg == 10'(SWR_SAMPLE_CYC - 1)) begin
                  cnt_reg   <= 10'h000;
                  state_reg <= SWR_HOLD;   // see R7
               end else
                  cnt_reg <= cnt_reg + 10'h001;
            end
            SWR_HOLD: begin
               // stays until input released and, for internal boot, flash ready
               if (!rst_low && (!boot_memory_select || flash_init_done)) begin
                  cnt_reg   <= 10'h000;
                  state_reg <= SWR_EXIT;   // see R10
               end
            end
            SWR_EXIT: begin
               if (boot_memory_select || cnt_reg == 10'(SWR_EXIT_CYC - 1))
                  state_reg <= SWR_IDLE;   // see R20
               else
                  cnt_reg <= cnt_reg + 10'h001;
            end
            SWR_ASYNC: begin
               // once asynchronous, completes as such even if the pin recovers
               if (!rst_low)
                  state_reg <= SWR_IDLE;   // see R13
            end
            default: state_reg <= SWR_IDLE;
         endcase
         // capacitor sensing only while the filtered input is low, hardware only
         if (!sw_reg && rst_low && !cap_high && busy && state_reg != SWR_ASYNC) begin
            state_reg      <= SWR_ASYNC;   // see R13 R14 R15
            async_flag_reg <= 1'b1;
         end
      end
   end

   // short and long classification
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         short_reg <= 1'b0;
         long_reg  <= 1'b0;
      end else if (clk_en) begin
         if (sample_end) begin
            short_reg <= 1'b1;
            long_reg  <= rst_low;   // see R7
         end
      end
   end

   // long-reset transparency of clock option bits
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         trans_reg     <= 1'b0;
         trans_cnt_reg <= 2'h0;
      end else if (clk_en) begin
         if (sample_end && rst_low) begin
            trans_reg     <= 1'b1;   // see R8
            trans_cnt_reg <= 2'h0;
         end else if (trans_reg && !rst_low) begin
            if (trans_cnt_reg == 2'(SWR_TRANS_END_CYC - 1))
               trans_reg <= 1'b0;   // see R8
            else
               trans_cnt_reg <= trans_cnt_reg + 2'h1;
         end
      end
   end

   // configuration latch
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_reg <= SWR_CFG_RESET;
      end else if (clk_en) begin
         if (trans_reg)
            cfg_reg[SWR_CLK_HI:SWR_CLK_LO] <= config_port[SWR_CLK_HI:SWR_CLK_LO];   // see R8
         if (exit_end) begin
            if (sw_reg) begin
               cfg_reg[SWR_SW_HI:SWR_SW_LO]   <= config_port[SWR_SW_HI:SWR_SW_LO];   // see R17
               cfg_reg[SWR_CLR_HI:SWR_CLR_LO] <= '1;
            end else
               cfg_reg <= config_port;   // see R11
         end
      end
   end

   // bidirectional enable and software reset request register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bidir_reg <= 1'b0;
         swreq_reg <= 1'b0;
      end else if (clk_en) begin
         swreq_reg <= 1'b0;
         if (busy)
            bidir_reg <= 1'b0;   // see R5
         else if (wr_en && addr_hit(paddr, SWR_CTRL_ADDR)) begin
            bidir_reg <= pwdata[SWR_CTRL_BIDIR_BIT];
            swreq_reg <= pwdata[SWR_CTRL_SWRST_BIT];
         end
      end
   end

   // bidirectional drive remembers enable captured at sequence start
   logic bidir_act_reg;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         bidir_act_reg <= 1'b0;
      else if (clk_en) begin
         if (state_reg == SWR_IDLE)
            bidir_act_reg <= bidir_reg;
         else if (state_reg == SWR_SAMPLE)
            bidir_act_reg <= 1'b0;
      end
   end

   // software reset with the capacitor low never pulls the pin; a later drop
   // of the capacitor releases it at once while the sequence runs on
   wire logic in_seq = (state_reg == SWR_SETTLE) || (state_reg == SWR_SEQ);
   wire logic drive_pin = bidir_act_reg && in_seq && (!sw_reg || cap_high);   // see R9 R18

   // pin outputs
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reset_input_n_o       <= 1'b1;
         reset_input_n_oe_n    <= 1'b1;
         powerdown_pulldown_en <= 1'b0;
         reset_output_n        <= 1'b1;
         io_tristate           <= 1'b0;
         bus_abort             <= 1'b0;
         hold_cancel           <= 1'b0;
         strobes_inactive      <= 1'b1;
         internal_reset        <= 1'b0;
         async_reset_req       <= 1'b0;
         flash_reset           <= 1'b0;
         fetch_addr            <= SWR_BOOT_ADDR;
         fetch_start           <= 1'b0;
      end else if (clk_en) begin
         reset_input_n_o       <= 1'b0;
         reset_input_n_oe_n    <= ~drive_pin;   // see R5 R9
         powerdown_pulldown_en <= rst_low | drive_pin;   // see R12
         if (busy && state_reg != SWR_DETECT)
            reset_output_n <= 1'b0;   // see R3
         io_tristate      <= busy && state_reg != SWR_DETECT;   // see R3
         bus_abort        <= state_reg == SWR_SETTLE;   // see R4
         hold_cancel      <= state_reg == SWR_SETTLE;   // see R4
         strobes_inactive <= busy || !fetch_start;
         internal_reset   <= busy && state_reg != SWR_DETECT;
         async_reset_req  <= state_reg == SWR_ASYNC;   // see R13
         flash_reset      <= flash_rst_reg;   // see R19
         fetch_start      <= 1'b0;
         if (exit_end) begin
            fetch_addr       <= SWR_BOOT_ADDR;   // see R11
            fetch_start      <= 1'b1;
            strobes_inactive <= 1'b1;   // see R11
         end
         if (async_flag_reg && state_reg == SWR_ASYNC && rst_low)
            reset_output_n <= 1'b0;
      end
   end

   assign system_config = cfg_reg;

   // apb read data
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         prdata <= 32'h0000_0000;
      else if (clk_en && psel && !penable && !pwrite) begin
         prdata <= 32'h0000_0000;
         if (addr_hit(paddr, SWR_CTRL_ADDR))
            prdata[SWR_CTRL_BIDIR_BIT] <= bidir_reg;
         else if (addr_hit(paddr, SWR_STATUS_ADDR)) begin
            prdata[SWR_STAT_SHORT_BIT] <= short_reg;
            prdata[SWR_STAT_LONG_BIT]  <= long_reg;
            prdata[SWR_STAT_SW_BIT]    <= sw_reg;
            prdata[SWR_STAT_ASYNC_BIT] <= async_flag_reg;
            prdata[SWR_STAT_BUSY_BIT]  <= busy;
         end else if (addr_hit(paddr, SWR_CFG_ADDR))
            prdata[15:0] <= cfg_reg;
      end
   end

   // unaligned or unused offsets answer with an error and read as zero
   function automatic logic reg_mapped(input logic [11:0] a);
      return addr_hit(a, SWR_CTRL_ADDR) || addr_hit(a, SWR_STATUS_ADDR)
             || addr_hit(a, SWR_CFG_ADDR);
   endfunction

   wire logic mapped = reg_mapped(paddr);
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~mapped;
endmodule
`default_nettype wire

// ===== sim/swr_monitor.sv
// port checker for the warm reset sequencer
`timescale 1ns/10ps
`default_nettype none
module swr_monitor
   import swr_pkg::*;
(
   // clock and run control
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic        clk_en,
   // apb
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [11:0] paddr,
   input wire logic        pslverr,
   // pins and sequence outputs
   input wire logic        filtered_reset_in,
   input wire logic        powerdown_cap_pin,
   input wire logic        boot_memory_select,
   input wire logic        flash_init_done,
   input wire logic        reset_input_n_oe_n,
   input wire logic        powerdown_pulldown_en,
   input wire logic        reset_output_n,
   input wire logic        io_tristate,
   input wire logic        bus_abort,
   input wire logic        internal_reset,
   input wire logic        async_reset_req,
   input wire logic        fetch_start,
   input wire logic [23:0] fetch_addr
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n || !clk_en);
   sequence warm_req;
      ($fell(filtered_reset_in) && powerdown_cap_pin) ##1
         (!filtered_reset_in && powerdown_cap_pin) [*3];
   endsequence
   sequence exit_pulse;
      (fetch_addr == SWR_BOOT_ADDR) ##1 !fetch_start;
   endsequence
   warm_start_a: assert property (warm_req |-> ##[0:8] !reset_output_n)
      else $error("reset output not driven after warm request");
   tristate_out_a: assert property ($rose(io_tristate) |-> ##[0:2] !reset_output_n)
      else $error("pins tristated without reset output low");
   bus_abort_a: assert property (warm_req |-> ##[0:14] bus_abort)
      else $error("external cycle not aborted in time");
   cap_pull_a: assert property (warm_req |-> ##[0:4] powerdown_pulldown_en)
      else $error("capacitor pull-down off while reset input low");
   exit_high_a: assert property (fetch_start |-> $past(filtered_reset_in, 2))
      else $error("exit while reset input still low");
   flash_wait_a: assert property (fetch_start && boot_memory_select |-> flash_init_done)
      else $error("internal boot exit before flash ready");
   exit_fetch_a: assert property ($rose(fetch_start) |-> exit_pulse)
      else $error("bad restart address or fetch pulse");
   async_keep_a: assert property (async_reset_req && !filtered_reset_in |=> async_reset_req)
      else $error("async reset dropped while input low");
   async_src_a: assert property ($rose(async_reset_req) |->
      !$past(filtered_reset_in, 4))
      else $error("async reset without filtered input low");
   bidir_span_a: assert property (!reset_input_n_oe_n |-> internal_reset)
      else $error("reset pin pulled outside sequence");
   apb_err_a: assert property (psel && penable |-> pslverr == !(paddr == SWR_CTRL_ADDR
      || paddr == SWR_STATUS_ADDR || paddr == SWR_CFG_ADDR))
      else $error("slave error flag wrong");
endmodule
bind swr_sequencer swr_monitor i_swr_monitor (.clk(clk), .rst_n(rst_n), .clk_en(clk_en),
   .psel(psel), .penable(penable), .paddr(paddr), .pslverr(pslverr),
   .filtered_reset_in(filtered_reset_in), .powerdown_cap_pin(powerdown_cap_pin),
   .boot_memory_select(boot_memory_select), .flash_init_done(flash_init_done),
   .reset_input_n_oe_n(reset_input_n_oe_n), .powerdown_pulldown_en(powerdown_pulldown_en),
   .reset_output_n(reset_output_n), .io_tristate(io_tristate), .bus_abort(bus_abort),
   .internal_reset(internal_reset), .async_reset_req(async_reset_req),
   .fetch_start(fetch_start), .fetch_addr(fetch_addr));
`default_nettype wire

// ===== sim/swr_ext_reset.sv
// model of the reset pin circuit, capacitor and flash init
`timescale 1ns/10ps
`default_nettype none
module swr_ext_reset #(
   parameter int FLASH = 30
) (
   // bench commands
   input  wire logic clk,
   input  wire logic press,
   input  wire logic cap_low,
   // device side
   input  wire logic reset_input_n_oe_n,
   output logic      filtered_reset_in,
   output logic      powerdown_cap_pin,
   output logic      flash_init_done
);
   logic [1:0] filt_q;
   int         fcnt;
   // pin has a pull-up; either the button or the open drain pulls it down
   wire logic  pin_lvl = !(press || !reset_input_n_oe_n);
   initial begin
      filt_q = 2'h3;
      fcnt = 0;
   end
   // two-cycle filter delay, so the filtered level lags the pin
   always @(posedge clk) begin
      filt_q <= {filt_q[0], pin_lvl};
      fcnt <= filt_q[1] ? ((fcnt < FLASH) ? fcnt + 1 : fcnt) : 0;
   end
   assign filtered_reset_in = filt_q[1];
   assign flash_init_done = (fcnt >= FLASH);
   // a small capacitor is modelled as already discharged when asked
   assign powerdown_cap_pin = !cap_low;
endmodule
`default_nettype wire

// ===== sim/tb_top.sv
// self-checking bench for the warm reset sequencer
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import swr_pkg::*;
   typedef struct {logic [31:0] m; logic [31:0] v; logic e;} swr_exp_t;
   logic        clk, rst_n, clk_en, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic        filtered_reset_in, powerdown_cap_pin, boot_memory_select, flash_init_done;
   logic        software_reset_instr, reset_input_n_o, reset_input_n_oe_n, powerdown_pulldown_en;
   logic        reset_output_n, io_tristate, bus_abort, hold_cancel, strobes_inactive;
   logic        internal_reset, async_reset_req, flash_reset, fetch_start, press, cap_low;
   logic [15:0] config_port, system_config, exp_cfg;
   logic [23:0] fetch_addr;
   int          fail_count, n_checks, fl_seen;
   swr_exp_t    e, rd_q[$];
   logic [15:0] cfg_q[$];
   swr_sequencer #(.SEQ_CYC(8)) i_swr_sequencer (.clk, .rst_n, .clk_en, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .filtered_reset_in,
      .powerdown_cap_pin, .boot_memory_select, .config_port, .flash_init_done,
      .software_reset_instr, .reset_input_n_o, .reset_input_n_oe_n, .powerdown_pulldown_en,
      .reset_output_n, .io_tristate, .bus_abort, .hold_cancel, .strobes_inactive,
      .internal_reset, .async_reset_req, .flash_reset, .fetch_addr, .fetch_start,
      .system_config);
   swr_ext_reset i_swr_ext_reset (.clk, .press, .cap_low, .reset_input_n_oe_n,
      .filtered_reset_in, .powerdown_cap_pin, .flash_init_done);
   task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk) penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(logic [11:0] a, logic [31:0] m, logic [31:0] v, logic err);
      rd_q.push_back('{m, v, err});
      apb(1'b0, a, 32'h0);
   endtask
   // waits for the restart pulse, noting whether the reset pin was pulled
   task automatic wait_exit(logic bidir);
      int n;
      logic oe;
      n = 0;
      oe = 1'b0;
      while (fetch_start !== 1'b1 && n < 3000) begin
         @(posedge clk);
         n++;
         oe |= (reset_input_n_oe_n === 1'b0);
      end
      check("restart seen", {31'h0, n < 3000}, 32'h1);
      check("pin pulled", {31'h0, oe}, {31'h0, bidir});
      repeat (2) @(posedge clk);
   endtask
   task automatic hw_reset(int low_cyc, logic bidir);
      exp_cfg = 16'($urandom);
      config_port <= exp_cfg;
      cfg_q.push_back(exp_cfg);
      press <= 1'b1;
      repeat (low_cyc) @(posedge clk);
      press <= 1'b0;
      wait_exit(bidir);
   endtask
   task automatic sw_reset(logic via_pin);
      logic [15:0] cp;
      cp = 16'($urandom);
      config_port <= cp;
      exp_cfg = {exp_cfg[15:13], cp[12:8], 6'h3f, exp_cfg[1:0]};
      cfg_q.push_back(exp_cfg);
      if (via_pin) begin
         software_reset_instr <= 1'b1;
         @(posedge clk) software_reset_instr <= 1'b0;
      end
      else apb(1'b1, SWR_CTRL_ADDR, 32'h1);
      wait_exit(1'b0);
   endtask
   always @(posedge clk) begin
      if (flash_reset === 1'b1) fl_seen++;
      if (psel && penable && pready && !pwrite && rd_q.size() > 0) begin
         e = rd_q.pop_front();
         check("prdata", prdata & e.m, e.v);
         check("pslverr", {31'h0, pslverr}, {31'h0, e.e});
      end
      if (fetch_start === 1'b1 && cfg_q.size() > 0) begin
         check("system_config", {16'h0, system_config}, {16'h0, cfg_q.pop_front()});
         check("fetch_addr", {8'h0, fetch_addr}, {8'h0, SWR_BOOT_ADDR});
      end
   end
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      final_report();
   end
   initial begin
      {rst_n, psel, penable, pwrite, paddr, pwdata, press, cap_low} = '0;
      {software_reset_instr, fail_count, n_checks, fl_seen} = '0;
      clk_en = 1'b1;
      boot_memory_select = 1'b1;
      config_port = 16'hffff;
      void'($urandom(66096));
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rd(SWR_CTRL_ADDR, 32'h8, 32'h0, 1'b0);
      rd(SWR_CFG_ADDR, 32'hffff, 32'hffff, 1'b0);
      rd(12'h0fc, 32'hffffffff, 32'h0, 1'b1);
      // short pulse: filter passes it, sequencer must not start
      press <= 1'b1;
      @(posedge clk) press <= 1'b0;
      repeat (30) @(posedge clk);
      check("no reset on short pulse", {31'h0, internal_reset}, 32'h0);
      check("flash reset pulses", fl_seen, 1);
      hw_reset(6, 1'b0);
      rd(SWR_STATUS_ADDR, 32'h3, 32'h1, 1'b0);
      sw_reset(1'b0);
      rd(SWR_STATUS_ADDR, 32'h4, 32'h4, 1'b0);
      cap_low <= 1'b1;
      sw_reset(1'b1);
      cap_low <= 1'b0;
      rd(SWR_STATUS_ADDR, 32'h8, 32'h0, 1'b0);
      apb(1'b1, SWR_CTRL_ADDR, 32'h8);
      rd(SWR_CTRL_ADDR, 32'h8, 32'h8, 1'b0);
      hw_reset(10, 1'b1);
      rd(SWR_CTRL_ADDR, 32'h8, 32'h0, 1'b0);
      boot_memory_select <= 1'b0;
      hw_reset(60, 1'b0);
      rd(SWR_STATUS_ADDR, 32'h3, 32'h3, 1'b0);
      boot_memory_select <= 1'b1;
      // capacitor drops during SWR_SETTLE, then recovers; async must complete
      press <= 1'b1;
      repeat (8) @(posedge clk);
      cap_low <= 1'b1;
      repeat (4) @(posedge clk);
      cap_low <= 1'b0;
      repeat (20) @(posedge clk);
      press <= 1'b0;
      repeat (60) @(posedge clk);
      rd(SWR_STATUS_ADDR, 32'h8, 32'h8, 1'b0);
      repeat (4) @(posedge clk);
      final_report();
   end
endmodule
`default_nettype wire
